// ===== hw/mem_init_consts.vh
// constants for the serial control port initialization block
// assumes inclusion by bare name from the design files under hw/ and the bench files under tb/
`ifndef MEM_INIT_CONSTS_VH
`define MEM_INIT_CONSTS_VH

// apb byte offsets
`define APB_CONTROL       8'h00
`define APB_STATUS        8'h04
`define APB_IDS           8'h08
// control register bits
`define CTL_SIO_RESET     0
`define CTL_CLR_ERR       1

// serial opcodes
`define OP_SRD            4'h0
`define OP_SWR            4'h1
`define OP_ASSERT_SOFT_RESET           4'h2
`define OP_FAST_CLOCK_SELECT           4'h4
`define OP_RELEASE_SOFT_RESET           4'hB
`define OP_PDN_WAKE       4'hC

// serial register addresses
`define SA_INIT           12'h021
`define SA_FIRST_TEST_REG         12'h022
`define SA_MEMORY_UNIT_ID          12'h040
`define SA_CCA            12'h043
`define SA_CCB            12'h044
`define SA_DOZE_EXIT_LEN           12'h045
`define SA_POWERDOWN_EXIT_FIRST          12'h046
`define SA_POWERDOWN_EXIT_TOTAL           12'h047
`define SA_READ_CORE_TIMING          12'h048
`define SA_CYCLE_TIME_REG         12'h049
`define SA_READ_DELAY_EXTRA         12'h04A
`define SA_FRAME_TIMING_REG           12'h04B
`define SA_SKIP           12'h04C
`define SA_TEST_REG_SEVENTY_SEVEN         12'h04D
`define SA_TEST_REG_SEVENTY_EIGHT         12'h04E
`define SA_TEST_REG_SEVENTY_NINE         12'h04F

// internal word indices
`define IX_INIT           4'd0
`define IX_FIRST_TEST_REG         4'd1
`define IX_MEMORY_UNIT_ID          4'd2
`define IX_CCA            4'd3
`define IX_CCB            4'd4
`define IX_DOZE_EXIT_LEN           4'd5
`define IX_POWERDOWN_EXIT_FIRST          4'd6
`define IX_POWERDOWN_EXIT_TOTAL           4'd7
`define IX_READ_CORE_TIMING          4'd8
`define IX_CYCLE_TIME_REG         4'd9
`define IX_READ_DELAY_EXTRA         4'd10
`define IX_FRAME_TIMING_REG           4'd11
`define IX_SKIP           4'd12
`define IX_TEST_REG_SEVENTY_SEVEN         4'd13
`define IX_TEST_REG_SEVENTY_EIGHT         4'd14
`define IX_TEST_REG_SEVENTY_NINE         4'd15

// setup, skip and memory unit id register fields
`define INIT_ID_LSB       0
`define INIT_ID_MSB       5
`define INIT_SRP          7
`define INIT_NSR          8
`define INIT_PSR          9
`define INIT_LSR          10
`define INIT_RESET        16'h00BF
`define SKIP_AS           0
`define MEMORY_UNIT_ID_MSB         4

// words cleared by serial port reset: first_test_reg, cca, ccb, skip, test_reg_seventy_eight, test_reg_seventy_nine, init
`define SIO_CLR_MASK      16'hD01B

// timing in serial clock cycles / samples
`define FRAME_PATTERN     8'hF0
`define ASSERT_SOFT_RESET_GAP          5'd16
`define FAST_CLOCK_SELECT_GAP          5'd4
`define FRAME_FALLS       5'd4
`define SIO_RST_SAMPLES   6'd32

`endif

// ===== hw/ctrl_reg_mem.v
// control register words with per-word clear and registered read
// assumes one write port, writes and clears from the same clock domain
`default_nettype none

module ctrl_reg_mem #(
  parameter W = 16,
  parameter N = 16,
  parameter AW = 4,
  parameter [N*W-1:0] RST = {N*W{1'b0}}
) (
  input  wire           clk,      // clock
  input  wire           rst_n,    // async reset, active low
  input  wire [N-1:0]   clr_mask, // words forced to reset value
  input  wire           we,       // write strobe
  input  wire [AW-1:0]  waddr,    // write index
  input  wire [W-1:0]   wdata,    // write data
  input  wire [AW-1:0]  raddr,    // read index
  output reg  [W-1:0]   rdata,    // registered read data
  output wire [N*W-1:0] words     // all words, flat
);

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_word
      reg [W-1:0] word;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          word <= RST[i*W +: W];
        else if (clr_mask[i])
          word <= RST[i*W +: W];
        else if (we && (waddr == i))
          word <= wdata;
      end
      assign words[i*W +: W] = word;
    end
  endgenerate

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= {W{1'b0}};
    else
      rdata <= words[raddr*W +: W];
  end

endmodule

`default_nettype wire

// ===== hw/mem_init_port.v
// device-side serial control port: framing, commands, power state, apb view
// assumes serial pins asynchronous to pclk and far slower than it
//
// Overview of operation
// - serial port reset clears six registers; setup register gets repeat and id ones
// - broadcast powerdown wake moves device from powerdown to relax
// - fast clock select stores auto sample bit and locks read domain
// - variant clear: start in attention, reset/fast commands need no match
// - variant set: start in powerdown, reset/fast commands need id match
// - release soft reset may leave core contents undefined
// - assert soft reset restores all registers; 16 cycles before release
// - fast clock select; 4 serial cycles before next command
`default_nettype none
`include "mem_init_consts.vh"

module mem_init_port (
  input  wire        pclk,              // system clock, 20 MHz
  input  wire        presetn,           // async reset, active low
  input  wire        psel,              // apb select
  input  wire        penable,           // apb enable
  input  wire        pwrite,            // apb direction
  input  wire [7:0]  paddr,             // apb byte address
  input  wire [31:0] pwdata,            // apb write data
  output reg  [31:0] prdata,            // apb read data
  output reg         pready,            // apb ready
  output reg         pslverr,           // apb error on unmapped address
  input  wire        init_variant_flag, // strap, caught after reset release
  input  wire        sck,               // serial clock pin
  input  wire        cmd,               // serial framing pin
  input  wire        sio0_i,            // chain pin toward controller, in
  output reg         sio0_o,            // chain pin toward controller, out
  output reg         sio0_oe_n,         // low while driving sio0
  input  wire        sio1_i,            // chain pin away from controller, in
  output reg         sio1_o,            // chain pin away, out
  output reg         sio1_oe_n,         // low while driving sio1
  input  wire        channel_clock_to_memory,               // channel clock pin
  output reg         relax_ready        // device in relax state
);

  localparam [4:0] S_HUNT = 5'b00001;
  localparam [4:0] S_SRQ  = 5'b00010;
  localparam [4:0] S_SA   = 5'b00100;
  localparam [4:0] S_P3   = 5'b01000;
  localparam [4:0] S_P4   = 5'b10000;
  localparam [3:0] P_BOOT = 4'b0001;
  localparam [3:0] P_ATTENTION_STATE = 4'b0010;
  localparam [3:0] P_PDN  = 4'b0100;
  localparam [3:0] P_RLX  = 4'b1000;

  function [4:0] map_addr;  // {valid, index}
    input [11:0] sa;
    begin
      case (sa)
        `SA_INIT:   map_addr = {1'b1, `IX_INIT};
        `SA_FIRST_TEST_REG: map_addr = {1'b1, `IX_FIRST_TEST_REG};
        `SA_MEMORY_UNIT_ID:  map_addr = {1'b1, `IX_MEMORY_UNIT_ID};
        `SA_CCA:    map_addr = {1'b1, `IX_CCA};
        `SA_CCB:    map_addr = {1'b1, `IX_CCB};
        `SA_DOZE_EXIT_LEN:   map_addr = {1'b1, `IX_DOZE_EXIT_LEN};
        `SA_POWERDOWN_EXIT_FIRST:  map_addr = {1'b1, `IX_POWERDOWN_EXIT_FIRST};
        `SA_POWERDOWN_EXIT_TOTAL:   map_addr = {1'b1, `IX_POWERDOWN_EXIT_TOTAL};
        `SA_READ_CORE_TIMING:  map_addr = {1'b1, `IX_READ_CORE_TIMING};
        `SA_CYCLE_TIME_REG: map_addr = {1'b1, `IX_CYCLE_TIME_REG};
        `SA_READ_DELAY_EXTRA: map_addr = {1'b1, `IX_READ_DELAY_EXTRA};
        `SA_FRAME_TIMING_REG:   map_addr = {1'b1, `IX_FRAME_TIMING_REG};
        `SA_SKIP:   map_addr = {1'b1, `IX_SKIP};
        `SA_TEST_REG_SEVENTY_SEVEN: map_addr = {1'b1, `IX_TEST_REG_SEVENTY_SEVEN};
        `SA_TEST_REG_SEVENTY_EIGHT: map_addr = {1'b1, `IX_TEST_REG_SEVENTY_EIGHT};
        `SA_TEST_REG_SEVENTY_NINE: map_addr = {1'b1, `IX_TEST_REG_SEVENTY_NINE};
        default:    map_addr = 5'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, level taken when stages two and three agree
  reg [2:0] sy_sck, sy_cmd, sy_s0, sy_s1, sy_ctm;
  reg       f_sck, f_cmd, f_s0, f_s1, f_ctm, sck_d;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy_sck <= 3'h0; sy_cmd <= 3'h0; sy_s0 <= 3'h0; sy_s1 <= 3'h0; sy_ctm <= 3'h0;
      f_sck <= 1'b0; f_cmd <= 1'b0; f_s0 <= 1'b0; f_s1 <= 1'b0; f_ctm <= 1'b0;
      sck_d <= 1'b0;
    end
    else
    begin
      sy_sck <= {sy_sck[1:0], sck};
      sy_cmd <= {sy_cmd[1:0], cmd};
      sy_s0  <= {sy_s0[1:0], sio0_i};
      sy_s1  <= {sy_s1[1:0], sio1_i};
      sy_ctm <= {sy_ctm[1:0], channel_clock_to_memory};
      if (sy_sck[1] == sy_sck[2]) f_sck <= sy_sck[2];
      if (sy_cmd[1] == sy_cmd[2]) f_cmd <= sy_cmd[2];
      if (sy_s0[1] == sy_s0[2])   f_s0  <= sy_s0[2];
      if (sy_s1[1] == sy_s1[2])   f_s1  <= sy_s1[2];
      if (sy_ctm[1] == sy_ctm[2]) f_ctm <= sy_ctm[2];
      sck_d <= f_sck;
    end
  end
  wire sck_fall = sck_d & ~f_sck;
  wire sck_rise = ~sck_d & f_sck;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [4:0]   state;
  reg  [3:0]   pwr;
  reg  [3:0]   bitcnt;
  reg  [15:0]  sh;
  reg  [7:0]   frame;
  reg  [3:0]   op;
  reg          sel;
  reg  [3:0]   ridx;
  reg          rvalid;
  reg  [15:0]  dout;
  reg          variant, soft_rst, fast_mode, err_assert_soft_reset, err_fast_clock_select, sio_req;
  reg  [4:0]   gap_assert_soft_reset, gap_fast_clock_select;
  reg  [5:0]   hi_cnt;
  reg          err_clr_pulse;
  reg          mem_we;
  reg  [3:0]   mem_waddr;
  reg  [15:0]  mem_wdata;
  wire [15:0]  mem_q;
  wire [255:0] words;
  wire [15:0]  init_word = words[`IX_INIT*16 +: 16];
  wire [15:0]  memory_unit_id_word = words[`IX_MEMORY_UNIT_ID*16 +: 16];
  wire [15:0]  skip_word = words[`IX_SKIP*16 +: 16];
  wire [5:0]   my_id = init_word[`INIT_ID_MSB:`INIT_ID_LSB];
  wire         repeat_on = init_word[`INIT_SRP];
  wire [15:0]  word_in = {sh[14:0], f_s0};
  wire [5:0]   sdev = {word_in[10], word_in[4:0]};
  wire         serial_broadcast_bit = word_in[5];
  wire [3:0]   sop = word_in[9:6];
  wire [4:0]   amap = map_addr(word_in[11:0]);
  wire         sio_rst = sio_req | (hi_cnt == `SIO_RST_SAMPLES);
  wire         sel_rst = variant ? (sdev == my_id) : 1'b1;
  wire         frame_hit = sck_fall & ({frame[6:0], f_cmd} == `FRAME_PATTERN);

  wire [15:0]  clr_mask = soft_rst ? 16'hFFFF : (sio_rst ? `SIO_CLR_MASK : 16'h0000);

  ctrl_reg_mem #(.W(16), .N(16), .AW(4),
                 .RST({240'h0, `INIT_RESET})) u_regs (
    .clk      (pclk),
    .rst_n    (presetn),
    .clr_mask (clr_mask),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (ridx),
    .rdata    (mem_q),
    .words    (words)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_HUNT; pwr <= P_BOOT; bitcnt <= 4'h0; sh <= 16'h0000; frame <= 8'h00;
      op <= 4'h0; sel <= 1'b0; ridx <= 4'h0; rvalid <= 1'b0; dout <= 16'h0000;
      variant <= 1'b0; soft_rst <= 1'b0; fast_mode <= 1'b0;
      err_assert_soft_reset <= 1'b0; err_fast_clock_select <= 1'b0; gap_assert_soft_reset <= 5'h1F; gap_fast_clock_select <= 5'h1F;
      hi_cnt <= 6'h00; mem_we <= 1'b0; mem_waddr <= 4'h0; mem_wdata <= 16'h0000;
      sio0_o <= 1'b0; sio0_oe_n <= 1'b1; sio1_o <= 1'b0; sio1_oe_n <= 1'b1;
      relax_ready <= 1'b0;
    end
    else
    begin
      mem_we <= 1'b0;
      relax_ready <= pwr[3];
      if (err_clr_pulse) err_assert_soft_reset <= 1'b0;
      if (err_clr_pulse) err_fast_clock_select <= 1'b0;
      if (pwr == P_BOOT)
      begin
        variant <= init_variant_flag;
        pwr <= init_variant_flag ? P_PDN : P_ATTENTION_STATE;
      end
      if (sck_fall | sck_rise)
      begin
        frame <= {frame[6:0], f_cmd};
        hi_cnt <= f_cmd ? ((hi_cnt == `SIO_RST_SAMPLES) ? hi_cnt : hi_cnt + 6'd1) : 6'd0;
      end
      // spacing counters
      // only idle and frame falls count, so a command's own packet bits cannot hide a short gap
      if (sck_fall && state == S_HUNT && gap_assert_soft_reset != 5'h1F) gap_assert_soft_reset <= gap_assert_soft_reset + 5'd1;
      if (sck_fall && state == S_HUNT && gap_fast_clock_select != 5'h1F) gap_fast_clock_select <= gap_fast_clock_select + 5'd1;
      if (sio_rst)
      begin
        state <= S_HUNT;
        bitcnt <= 4'h0;
      end
      else if (frame_hit && state == S_HUNT)
      begin
        state <= S_SRQ;
        bitcnt <= 4'h0;
        // early command flagged
        // the hit falls on the fourth frame fall; the first three are already counted
        if (gap_fast_clock_select < `FAST_CLOCK_SELECT_GAP + `FRAME_FALLS - 5'd1) err_fast_clock_select <= 1'b1;
      end
      else if (sck_fall && state != S_HUNT)
      begin
        sh <= word_in;
        bitcnt <= bitcnt + 4'd1;
        if (bitcnt == 4'hF)
        begin
          case (state)
            S_SRQ:
            begin
              op <= sop;
              sel <= serial_broadcast_bit | (sdev == my_id);
              state <= (sop == `OP_SWR || sop == `OP_SRD) ? S_SA : S_HUNT;
              if (sop == `OP_ASSERT_SOFT_RESET && sel_rst)
              begin
                soft_rst <= 1'b1;
                gap_assert_soft_reset <= 5'd0;
              end
              if (sop == `OP_RELEASE_SOFT_RESET && sel_rst)
              begin
                soft_rst <= 1'b0;
                if (gap_assert_soft_reset < `ASSERT_SOFT_RESET_GAP + `FRAME_FALLS) err_assert_soft_reset <= 1'b1;
                gap_fast_clock_select <= 5'd0;
              end
              if (sop == `OP_FAST_CLOCK_SELECT && sel_rst)
              begin
                fast_mode <= 1'b1;
                gap_fast_clock_select <= 5'd0;
                mem_we <= 1'b1;
                mem_waddr <= `IX_SKIP;
                mem_wdata <= {skip_word[15:1], f_ctm};
              end
              if (sop == `OP_PDN_WAKE && serial_broadcast_bit && pwr == P_PDN)
                pwr <= P_RLX;
            end
            S_SA:
            begin
              ridx <= amap[3:0];
              rvalid <= amap[4];
              state <= S_P3;
            end
            S_P3:
            begin
              if (op == `OP_SWR && sel && rvalid)
              begin
                mem_we <= 1'b1;
                mem_waddr <= ridx;
                mem_wdata <= word_in;
              end
              dout <= rvalid ? mem_q : 16'h0000;
              state <= S_P4;
            end
            S_P4:
              state <= S_HUNT;
            default:
              state <= S_HUNT;
          endcase
        end
      end
      // read data turns toward the controller; far-device data is repeated back
      if (state == S_P4 && op == `OP_SRD)
      begin
        sio1_oe_n <= 1'b1;
        sio0_oe_n <= ~(sel | repeat_on);
        if (sel && sck_rise)
          sio0_o <= dout[4'hF - bitcnt];
        else if (!sel)
          sio0_o <= f_s1;
      end
      else
      begin
        sio0_oe_n <= 1'b1;
        sio1_oe_n <= ~repeat_on;
        sio1_o <= f_s0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access phase
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0; prdata <= 32'h00000000; pslverr <= 1'b0;
      sio_req <= 1'b0; err_clr_pulse <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      sio_req <= apb_wr && paddr == `APB_CONTROL && pwdata[`CTL_SIO_RESET];
      err_clr_pulse <= apb_wr && paddr == `APB_CONTROL && pwdata[`CTL_CLR_ERR];
      if (apb_setup)
      begin
        pslverr <= ~(paddr == `APB_CONTROL || paddr == `APB_STATUS || paddr == `APB_IDS);
        case (paddr)
          `APB_STATUS:
            prdata <= {22'h0, err_fast_clock_select, err_assert_soft_reset, variant, soft_rst, fast_mode,
                       skip_word[`SKIP_AS], pwr};
          `APB_IDS:
            prdata <= {16'h0, 3'h0, memory_unit_id_word[`MEMORY_UNIT_ID_MSB:0], 2'h0, my_id};
          default:
            prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== tb/mem_init_port_assertions.sv
// assertions on the apb answer and pin states of the init port
// assumes a bind onto mem_init_port; sees its ports only
`default_nettype none
module mem_init_port_checker (
  input wire logic        pclk,              // clock
  input wire logic        presetn,           // reset
  input wire logic        psel,              // select
  input wire logic        penable,           // enable
  input wire logic        pwrite,            // direction
  input wire logic [7:0]  paddr,             // address
  input wire logic [31:0] prdata,            // read data
  input wire logic        pready,            // ready
  input wire logic        pslverr,           // error
  input wire logic        init_variant_flag, // strap
  input wire logic        sio0_oe_n,         // drive enable
  input wire logic        sio1_oe_n,         // drive enable
  input wire logic        relax_ready        // relax state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped;
  wire logic rd_st;
  wire logic rd_id;
  assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
  assign rd_st = pready && !pwrite && paddr == 8'h04;
  assign rd_id = pready && !pwrite && paddr == 8'h08;
////////////////////////////////////////////////////////////////////////////////
  a_ready_timing: assert property (pready == $past(psel && !penable))
    else $error("ready not one cycle after setup");
  a_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("error flag does not match address decode");
  a_err_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused access returned data");
  a_ctrl_zero: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == 32'h0)
    else $error("control word read not zero");
  a_state_onehot: assert property (rd_st |-> $onehot(prdata[3:0]))
    else $error("power state not one-hot");
  a_relax_status: assert property (rd_st |-> prdata[3] == relax_ready)
    else $error("relax pin and status disagree");
  a_variant_status: assert property (rd_st |-> prdata[7] == init_variant_flag)
    else $error("variant bit wrong");
  a_ids_spare: assert property (rd_id |-> prdata[31:13] == 19'h0 && prdata[7:6] == 2'h0)
    else $error("spare id bits set");
  a_reset_quiet: assert property ($rose(presetn) |-> sio0_oe_n && sio1_oe_n && !relax_ready)
    else $error("pins active out of reset");
endmodule
`default_nettype wire

// ===== tb/mem_ctl_model.sv
// memory controller model on the serial control port: framing, packets, gaps
// assumes the bench calls its tasks; sck stands low outside transfers
`default_nettype none
`include "mem_init_consts.vh"
module mem_ctl_model (
  output logic     sck,  // serial clock
  output logic     cmd,  // framing
  output logic     pd,   // data toward device
  output logic     p_oe, // high while driving sio0
  input wire logic sio0  // sio0 wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sck = 1'b0;
    cmd = 1'b0;
    pd = 1'b0;
    p_oe = 1'b1;
  end
////////////////////////////////////////////////////////////////////////////////
  // cmd moves mid half period, well clear of the edge the port samples
  task automatic half(input logic c);
    cmd = c;
    #100;
    sck = ~sck;
    #100;
  endtask
  task automatic pkt(input logic [15:0] w, output logic [15:0] v);
    for (int i = 15; i >= 0; i--)
    begin
      pd = w[i];
      half(1'b0);
      half(1'b0);
      // read bits move on the rise through a slow sync, so sample late
      v[i] = sio0;
    end
  endtask
  task automatic gap(input int n);
    repeat (2 * n) half(1'b0);
  endtask
  // refresh, trims and memory packets stay on the channel
  task automatic xact(input logic [3:0] op, input logic bc, input logic [5:0] dv,
                      input logic [11:0] sa, input logic [15:0] sd, output logic [15:0] rd);
    logic [15:0] v;
    rd = 16'h0000;
    // start 10 ns late; back-to-back calls drift 10 ns each, so some pin moves land on a pclk rise
    #10;
    for (int i = 0; i < 8; i++) half(i < 4);
    pkt({5'h00, dv[5], op, bc, dv[4:0]}, v);
    if (op == `OP_SRD || op == `OP_SWR)
    begin
      pkt({4'h0, sa}, v);
      pkt(op == `OP_SWR ? sd : 16'h0000, v);
      p_oe = (op == `OP_SWR);
      pkt(16'h0000, rd);
      p_oe = 1'b1;
    end
    #600;
  endtask
endmodule
`default_nettype wire

// ===== tb/mem_init_port_tb.sv
// top bench: apb master and serial controller model around the init port
// assumes the checker and the controller model are compiled first
`default_nettype none
`include "mem_init_consts.vh"
module mem_init_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, init_variant_flag, channel_clock_to_memory, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, sck, cmd, pd, p_oe;
  logic        sio0_o, sio0_oe_n, sio1_o, sio1_oe_n, relax_ready;
  logic        far_sio;
  logic [15:0] r;
  logic [5:0]  dev;
  int          bad_count, total_checks;
  // a released line shows the inverse of its last value
  wire logic   sio0 = !sio0_oe_n ? sio0_o : (p_oe ? pd : !pd);
  mem_init_port u_mem_init_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .init_variant_flag(init_variant_flag), .sck(sck),
    .cmd(cmd), .sio0_i(sio0), .sio0_o(sio0_o), .sio0_oe_n(sio0_oe_n), .sio1_i(far_sio),
    .sio1_o(sio1_o), .sio1_oe_n(sio1_oe_n), .channel_clock_to_memory(channel_clock_to_memory), .relax_ready(relax_ready));
  mem_ctl_model u_mem_ctl_model (.sck(sck), .cmd(cmd), .pd(pd), .p_oe(p_oe), .sio0(sio0));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      bad_count++;
      results();
    end
  endtask
  task automatic st;
    apb(1'b0, `APB_STATUS, 32'h0);
  endtask
  task automatic ser(input logic [3:0] op, input logic bc, input logic [11:0] sa,
                     input logic [15:0] d);
    u_mem_ctl_model.xact(op, bc, dev, sa, d, r);
  endtask
  task automatic boot(input logic v);
    presetn <= 1'b0;
    init_variant_flag <= v;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    boot(1'b0);
    st();
    chk("power state", 32'h2, q[3:0]);
    apb(1'b0, `APB_CONTROL, 32'h0);
    chk("control reads zero", 32'h0, q);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped error", 32'h1, e);
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic t_sio_reset;
    logic [11:0] cl [6];
    cl = '{`SA_FIRST_TEST_REG, `SA_CCA, `SA_CCB, `SA_SKIP, `SA_TEST_REG_SEVENTY_EIGHT, `SA_TEST_REG_SEVENTY_NINE};
    dev = 6'h3F;
    apb(1'b1, `APB_CONTROL, 32'h1);
    ser(`OP_SWR, 1'b0, `SA_TEST_REG_SEVENTY_SEVEN, 16'h0000);
    foreach (cl[i]) ser(`OP_SWR, 1'b0, cl[i], 16'h0005);
    ser(`OP_SRD, 1'b0, `SA_CCA, 16'h0);
    chk("lane a written", 32'h5, r);
    // cmd held high for 32 samples resets the port from the pins
    repeat (33) u_mem_ctl_model.half(1'b1);
    u_mem_ctl_model.half(1'b0);
    ser(`OP_SWR, 1'b0, `SA_TEST_REG_SEVENTY_SEVEN, 16'h0000);
    ser(`OP_SRD, 1'b0, `SA_CCA, 16'h0);
    chk("pin reset lane a", 32'h0, r);
    apb(1'b1, `APB_CONTROL, 32'h1);
    ser(`OP_SWR, 1'b0, `SA_TEST_REG_SEVENTY_SEVEN, 16'h0000);
    foreach (cl[i])
    begin
      ser(`OP_SRD, 1'b0, cl[i], 16'h0);
      chk("cleared word", 32'h0, r);
    end
    ser(`OP_SRD, 1'b0, `SA_INIT, 16'h0);
    chk("setup word", 32'h00BF, r);
  endtask
  task automatic t_ids;
    logic [11:0] cfg [5];
    cfg = '{`SA_DOZE_EXIT_LEN, `SA_POWERDOWN_EXIT_FIRST, `SA_POWERDOWN_EXIT_TOTAL, `SA_READ_CORE_TIMING, `SA_READ_DELAY_EXTRA};
    ser(`OP_SWR, 1'b0, `SA_CYCLE_TIME_REG, 16'h0027);
    ser(`OP_SWR, 1'b0, `SA_INIT, 16'h0080);
    dev = 6'h00;
    ser(`OP_SWR, 1'b0, `SA_MEMORY_UNIT_ID, 16'h0005);
    foreach (cfg[i]) ser(`OP_SWR, 1'b0, cfg[i], 16'h0003);
    ser(`OP_SRD, 1'b0, `SA_READ_CORE_TIMING, 16'h0);
    chk("read timing", 32'h3, r);
    ser(`OP_SRD, 1'b0, `SA_CYCLE_TIME_REG, 16'h0);
    chk("cycle time", 32'h27, r);
    apb(1'b0, `APB_IDS, 32'h0);
    chk("ids", 32'h0000_0500, q);
    // a read for a farther device comes back through this one
    @(posedge pclk);
    far_sio <= 1'b1;
    dev = 6'h01;
    ser(`OP_SRD, 1'b0, `SA_CYCLE_TIME_REG, 16'h0);
    chk("repeated far data", 32'hFFFF, r);
    @(posedge pclk);
    far_sio <= 1'b0;
    dev = 6'h00;
  endtask
  task automatic t_soft_reset;
    ser(`OP_ASSERT_SOFT_RESET, 1'b0, 12'h0, 16'h0);
    st();
    chk("soft reset on", 32'h1, q[6]);
    u_mem_ctl_model.gap(16);
    ser(`OP_RELEASE_SOFT_RESET, 1'b0, 12'h0, 16'h0);
    u_mem_ctl_model.gap(4);
    st();
    chk("soft reset off", 32'h0, q[6]);
    chk("gap error", 32'h0, q[8]);
    apb(1'b0, `APB_IDS, 32'h0);
    chk("memory id restored", 32'h0, q[12:8]);
    ser(`OP_SWR, 1'b1, `SA_CCA, 16'h0040);
    ser(`OP_SWR, 1'b1, `SA_CCB, 16'h0040);
    ser(`OP_SRD, 1'b1, `SA_CCB, 16'h0);
    chk("lane b midpoint", 32'h40, r);
    // a second, too close pair is sent on purpose to raise the gap flag
    ser(`OP_ASSERT_SOFT_RESET, 1'b0, 12'h0, 16'h0);
    u_mem_ctl_model.gap(2);
    ser(`OP_RELEASE_SOFT_RESET, 1'b0, 12'h0, 16'h0);
    u_mem_ctl_model.gap(4);
    st();
    chk("short gap flagged", 32'h1, q[8]);
    apb(1'b1, `APB_CONTROL, 32'h2);
    st();
    chk("gap flag cleared", 32'h0, q[8]);
  endtask
  task automatic t_fast;
    @(posedge pclk);
    channel_clock_to_memory <= 1'b1;
    ser(`OP_FAST_CLOCK_SELECT, 1'b0, 12'h0, 16'h0);
    u_mem_ctl_model.gap(4);
    st();
    chk("auto sample", 32'h1, q[4]);
    chk("fast lock", 32'h1, q[5]);
    chk("spacing flag", 32'h0, q[9]);
    ser(`OP_SWR, 1'b1, `SA_READ_CORE_TIMING, 16'h0005);
    ser(`OP_SWR, 1'b1, `SA_INIT, 16'h07BF);
    ser(`OP_SRD, 1'b1, `SA_INIT, 16'h0);
    chk("final setup", 32'h07BF, r);
  endtask
  task automatic t_wake;
    boot(1'b1);
    st();
    chk("power state", 32'h4, q[3:0]);
    chk("variant", 32'h1, q[7]);
    dev = 6'h15;
    ser(`OP_ASSERT_SOFT_RESET, 1'b1, 12'h0, 16'h0);
    st();
    chk("broadcast reset ignored", 32'h0, q[6]);
    chk("repeat enable", 32'h0, sio1_oe_n);
    chk("repeat out", 32'h1, sio1_o);
    chk("not relaxed", 32'h0, relax_ready);
    ser(`OP_PDN_WAKE, 1'b1, 12'h0, 16'h0);
    st();
    chk("relax state", 32'h8, q[3:0]);
    chk("relax pin", 32'h1, relax_ready);
    // a command right behind a release breaks the spacing on purpose
    dev = 6'h3F;
    ser(`OP_RELEASE_SOFT_RESET, 1'b0, 12'h0, 16'h0);
    ser(`OP_SRD, 1'b0, `SA_SKIP, 16'h0);
    st();
    chk("spacing flagged", 32'h1, q[9]);
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    init_variant_flag = 1'b0;
    channel_clock_to_memory = 1'b0;
    far_sio = 1'b0;
    dev = 6'h00;
    t_boot();
    t_sio_reset();
    t_ids();
    t_soft_reset();
    t_fast();
    t_wake();
    results();
  end
  initial
  begin
    #3000000;
    bad_count++;
    results();
  end
endmodule
bind mem_init_port mem_init_port_checker u_mem_init_port_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .init_variant_flag(init_variant_flag),
  .sio0_oe_n(sio0_oe_n), .sio1_oe_n(sio1_oe_n), .relax_ready(relax_ready));
`default_nettype wire
